//--- logic/an_regs_pkg.sv
package an_regs_pkg;

    // ------------------------------------------------------------
    // register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CONTROL = 12'h4C0;
    localparam logic [11:0] IDX_STATUS = 12'h4C2;
    localparam logic [11:0] IDX_BP_LOW = 12'h4C3;
    localparam logic [11:0] IDX_BP_HIGH = 12'h4C4;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int CTL_BASE_PAGE_BIT = 1;
    localparam int CTL_OVERRIDE_BIT = 5;
    localparam logic [31:0] CTL_WMASK = 32'h0000_0022;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int ST_PAGE_RX_BIT = 1;
    localparam int ST_COMPLETE_BIT = 2;
    localparam int ST_RF_SENT_BIT = 3;
    localparam int ST_RX_IDLE_BIT = 4;
    localparam int ST_ABILITY_BIT = 5;
    localparam int ST_LINK_BIT = 6;
    localparam int ST_LP_ABLE_BIT = 7;
    localparam int ST_FEC_BIT = 8;
    localparam int ST_SEQ_FAIL_BIT = 9;
    localparam int ST_READY_LSB = 12;
    localparam int ST_READY_W = 6;

    // ------------------------------------------------------------
    // base page low and high word / override fields
    // ------------------------------------------------------------
    localparam logic [31:0] BPL_WMASK = 32'h733F_FFFF;
    localparam logic [31:0] BPL_RESET = 32'h0000_0000;
    localparam logic [31:0] BPH_RESET = 32'h0000_0000;
    localparam int BPL_ACK_BIT = 14;
    localparam int BPL_NONCE_LSB = 5;
    localparam int BPL_NONCE_W = 5;
    localparam int OVR_TECH_LSB = 16;
    localparam int OVR_TECH_W = 6;
    localparam int OVR_FEC_LSB = 24;
    localparam int OVR_FEC_W = 2;
    localparam int OVR_PAUSE_LSB = 28;
    localparam int OVR_PAUSE_W = 3;
    localparam int BPH_TECH_LSB = 5;
    localparam int BPH_TECH_W = 25;
    localparam int BPH_NONCE_W = 5;

endpackage : an_regs_pkg

//--- logic/kr_autoneg_status_basepage_regs.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - page-received bit sets on partner page, clears when status is read
// - complete bit follows negotiation finished level
// - remote-fault-sent bit sets when fault sent, clears on status read
// - receive idle bit follows receive machine idle on non-negotiation data
// - negotiation ability bit is constant one
// - link bit latches link up, clears on status read
// - partner-capable bit follows partner ability level
// - fec bit follows negotiated forward error correction level
// - sequencer failure bit follows sequencer failure level
// - link-ready field is the one-hot resolved technology indication
// - user low word supplies page bits 15, 13:10 and 4:0 when user pages enabled
// - acknowledge and echoed nonce always come from transmit machine
// - pseudo-random page bit 49 always from transmit machine
// - low word 21:16 holds technology override bits
// - low word 25:24 holds fec override bits
// - low word 30:28 holds the three pause override bits
// - overrides apply only while control bit 5 is set
// - high word gives technology bits 45:21 and nonce bits 20:16
// - base-page bit selects user pages or machine-built pages
module kr_autoneg_status_basepage_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // classic wishbone slave
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    // negotiation engine events and levels
    input wire logic page_received_i,
    input wire logic negotiation_complete_i,
    input wire logic remote_fault_sent_i,
    input wire logic receive_negotiation_idle_i,
    input wire logic link_up_i,
    input wire logic partner_negotiation_capable_i,
    input wire logic fec_negotiated_i,
    input wire logic sequencer_negotiation_failure_i,
    input wire logic [5:0] resolved_link_ready_onehot_i,
    // transmit machine owned page bits
    input wire logic tx_ack_i,
    input wire logic [4:0] tx_echoed_nonce_i,
    input wire logic tx_prbs_i,
    // page and override outputs to the transmit machine
    output logic user_base_page_en_o,
    output logic [49:0] user_base_page_o,
    output logic override_en_o,
    output logic [5:0] advertised_technology_override_o,
    output logic [1:0] advertised_fec_override_o,
    output logic [2:0] advertised_pause_override_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] control;
        logic [31:0] bp_low;
        logic [31:0] bp_high;
        logic page_rx;
        logic rf_sent;
        logic link;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t state_q;
    state_t state_d;

    // merge write data through byte enables and a writable mask
    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel,
        input logic [31:0] wmask
    );
        logic [31:0] lanes;
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        lanes = lanes & wmask;
        return (old_val & ~lanes) | (new_val & lanes);
    endfunction : merge_write

    logic req;
    logic [11:0] word_idx;
    logic [31:0] status_word;

    assign req = wb_cyc_i & wb_stb_i & ~state_q.ack;
    assign word_idx = wb_adr_i[13:2];

    // ------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------
    // undriven positions stay zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[an_regs_pkg::ST_PAGE_RX_BIT] = state_q.page_rx;
        status_word[an_regs_pkg::ST_COMPLETE_BIT] =
            negotiation_complete_i;
        status_word[an_regs_pkg::ST_RF_SENT_BIT] = state_q.rf_sent;
        status_word[an_regs_pkg::ST_RX_IDLE_BIT] =
            receive_negotiation_idle_i;
        status_word[an_regs_pkg::ST_ABILITY_BIT] = 1'b1;
        status_word[an_regs_pkg::ST_LINK_BIT] = state_q.link;
        status_word[an_regs_pkg::ST_LP_ABLE_BIT] =
            partner_negotiation_capable_i;
        status_word[an_regs_pkg::ST_FEC_BIT] = fec_negotiated_i;
        status_word[an_regs_pkg::ST_SEQ_FAIL_BIT] =
            sequencer_negotiation_failure_i;
        status_word[an_regs_pkg::ST_READY_LSB +: an_regs_pkg::ST_READY_W] =
            resolved_link_ready_onehot_i;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // sticky bits: an event in the read cycle survives, set beats clear
    always_comb begin
        state_d = state_q;
        state_d.ack = req;
        if (req && !wb_we_i) begin
            unique case (word_idx)
                an_regs_pkg::IDX_CONTROL: state_d.rdata = state_q.control;
                an_regs_pkg::IDX_STATUS: state_d.rdata = status_word;
                an_regs_pkg::IDX_BP_LOW: state_d.rdata = state_q.bp_low;
                an_regs_pkg::IDX_BP_HIGH: state_d.rdata = state_q.bp_high;
                default: state_d.rdata = 32'h0000_0000;
            endcase
        end
        if (req && !wb_we_i && word_idx == an_regs_pkg::IDX_STATUS) begin
            state_d.page_rx = 1'b0;
            state_d.rf_sent = 1'b0;
            state_d.link = 1'b0;
        end
        if (page_received_i) begin
            state_d.page_rx = 1'b1;
        end
        if (remote_fault_sent_i) begin
            state_d.rf_sent = 1'b1;
        end
        if (link_up_i) begin
            state_d.link = 1'b1;
        end
        if (req && wb_we_i) begin
            unique case (word_idx)
                an_regs_pkg::IDX_CONTROL: begin
                    state_d.control = merge_write(state_q.control, wb_dat_i,
                        wb_sel_i, an_regs_pkg::CTL_WMASK);
                end
                an_regs_pkg::IDX_BP_LOW: begin
                    state_d.bp_low = merge_write(state_q.bp_low, wb_dat_i,
                        wb_sel_i, an_regs_pkg::BPL_WMASK);
                end
                an_regs_pkg::IDX_BP_HIGH: begin
                    state_d.bp_high = merge_write(state_q.bp_high, wb_dat_i,
                        wb_sel_i, 32'hFFFF_FFFF);
                end
                default: begin
                    state_d.rdata = state_q.rdata; // unmapped write dropped
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q.control <= an_regs_pkg::CTL_RESET;
            state_q.bp_low <= an_regs_pkg::BPL_RESET;
            state_q.bp_high <= an_regs_pkg::BPH_RESET;
            state_q.page_rx <= 1'b0;
            state_q.rf_sent <= 1'b0;
            state_q.link <= 1'b0;
            state_q.ack <= 1'b0;
            state_q.rdata <= 32'h0000_0000;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = state_q.ack;
    assign wb_dat_o = state_q.rdata;

    // selects user words versus machine-built page
    assign user_base_page_en_o =
        state_q.control[an_regs_pkg::CTL_BASE_PAGE_BIT];

    // page bits 45:16 from the high word bit 49 from machine
    // upper bits 48:46 come from no user word, so they stay zero
    always_comb begin
        user_base_page_o = 50'h0;
        user_base_page_o[15:0] = state_q.bp_low[15:0];
        user_base_page_o[an_regs_pkg::BPL_ACK_BIT] = tx_ack_i;
        user_base_page_o[an_regs_pkg::BPL_NONCE_LSB +:
            an_regs_pkg::BPL_NONCE_W] = tx_echoed_nonce_i;
        user_base_page_o[20:16] =
            state_q.bp_high[an_regs_pkg::BPH_NONCE_W-1:0];
        user_base_page_o[45:21] = state_q.bp_high[an_regs_pkg::BPH_TECH_LSB
            +: an_regs_pkg::BPH_TECH_W];
        user_base_page_o[49] = tx_prbs_i;
    end

    // overrides gated by control bit 5; sequencer restart is software's
    assign override_en_o =
        state_q.control[an_regs_pkg::CTL_OVERRIDE_BIT];
    assign advertised_technology_override_o = override_en_o ?
        state_q.bp_low[an_regs_pkg::OVR_TECH_LSB +: an_regs_pkg::OVR_TECH_W]
        : 6'h00;
    assign advertised_fec_override_o = override_en_o ?
        state_q.bp_low[an_regs_pkg::OVR_FEC_LSB +: an_regs_pkg::OVR_FEC_W]
        : 2'h0;
    assign advertised_pause_override_o = override_en_o ?
        state_q.bp_low[an_regs_pkg::OVR_PAUSE_LSB +: an_regs_pkg::OVR_PAUSE_W]
        : 3'h0;

endmodule : kr_autoneg_status_basepage_regs

`default_nettype wire

//--- bench/an_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// negotiation engine stand-in: live levels and transmit bits
// ------------------------------------------------------------
module an_engine_model (
    input wire logic clk_i,
    output logic [4:0] lvl_o,
    output logic [5:0] ready_o,
    output logic ack_o,
    output logic [4:0] nonce_o,
    output logic prbs_o
);
    int seed = 77693;
    initial {lvl_o, ready_o, ack_o, nonce_o, prbs_o} = 18'h0;
    // fresh values every cycle, so a stale capture shows up at once
    always @(posedge clk_i) begin
        lvl_o <= 5'($random(seed));
        ready_o <= 6'h01 << ($unsigned($random(seed)) % 7);
        {ack_o, nonce_o, prbs_o} <= 7'($random(seed));
    end
endmodule : an_engine_model
`default_nettype wire

//--- bench/an_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port-level checks, one clock domain
// ------------------------------------------------------------
module an_regs_checker (
    input wire logic clk_i, rst_i, ce_i,
    input wire logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic negotiation_complete_i, receive_negotiation_idle_i,
    input wire logic partner_negotiation_capable_i, fec_negotiated_i,
    input wire logic sequencer_negotiation_failure_i, page_received_i,
    input wire logic [5:0] resolved_link_ready_onehot_i,
    input wire logic tx_ack_i, tx_prbs_i, user_base_page_en_o, override_en_o,
    input wire logic [4:0] tx_echoed_nonce_i,
    input wire logic [49:0] user_base_page_o,
    input wire logic [5:0] advertised_technology_override_o,
    input wire logic [1:0] advertised_fec_override_o,
    input wire logic [2:0] advertised_pause_override_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // requests taken on this edge, only while the clock enable is high
    sequence rd_st;
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
            && wb_adr_i[13:2] == an_regs_pkg::IDX_STATUS;
    endsequence
    sequence wr_ctl;
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i[13:2] == an_regs_pkg::IDX_CONTROL;
    endsequence
    a_ack_pulse: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one cycle answer");
    a_ability_one: assert property (
        rd_st |=> wb_dat_o[5]) else $error("ability bit low");
    a_live_levels: assert property (
        rd_st |=> wb_dat_o[2] == $past(negotiation_complete_i)
            && wb_dat_o[7] == $past(partner_negotiation_capable_i))
        else $error("complete or partner bit wrong");
    a_idle_fec: assert property (
        rd_st |=> wb_dat_o[4] == $past(receive_negotiation_idle_i)
            && wb_dat_o[8] == $past(fec_negotiated_i))
        else $error("idle or fec bit wrong");
    a_seq_fail: assert property (
        rd_st |=> wb_dat_o[9] == $past(sequencer_negotiation_failure_i))
        else $error("sequencer failure bit wrong");
    a_ready_hot: assert property (
        rd_st |=> wb_dat_o[17:12] == $past(resolved_link_ready_onehot_i))
        else $error("link ready field wrong");
    a_page_sticky: assert property (
        page_received_i && ce_i ##1 rd_st |=> wb_dat_o[1])
        else $error("page received bit lost");
    a_tx_owned: assert property (
        user_base_page_o[14] == tx_ack_i && user_base_page_o[49] == tx_prbs_i
            && user_base_page_o[9:5] == tx_echoed_nonce_i)
        else $error("machine owned page bits wrong");
    a_ovr_gate: assert property (
        !override_en_o |-> {advertised_technology_override_o,
            advertised_fec_override_o, advertised_pause_override_o} == 11'h0)
        else $error("override leaks while disabled");
    a_ctl_write: assert property (
        wr_ctl |=> user_base_page_en_o == $past(wb_dat_i[1])
            && override_en_o == $past(wb_dat_i[5]))
        else $error("control enables not updated");
endmodule : an_regs_checker
bind kr_autoneg_status_basepage_regs an_regs_checker u_an_regs_checker (.*);
`default_nettype wire

//--- bench/kr_autoneg_status_basepage_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// register bank bench
// ------------------------------------------------------------
module kr_autoneg_status_basepage_regs_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, tx_ack_i, tx_prbs_i;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic page_received_i = 1'b0, remote_fault_sent_i = 1'b0;
    logic link_up_i = 1'b0, user_base_page_en_o, override_en_o;
    logic negotiation_complete_i, receive_negotiation_idle_i;
    logic partner_negotiation_capable_i, fec_negotiated_i;
    logic sequencer_negotiation_failure_i;
    logic [5:0] resolved_link_ready_onehot_i, advertised_technology_override_o;
    logic [4:0] tx_echoed_nonce_i;
    logic [49:0] user_base_page_o;
    logic [1:0] advertised_fec_override_o;
    logic [2:0] advertised_pause_override_o;
    logic [31:0] rdat, snap, wd, mdl [0:3];
    logic [3:0] ws;
    logic [11:0] idx [0:3];
    logic [31:0] wm [0:3];
    int error_cnt = 0, tests_run = 0, seed = 77693, k;

    kr_autoneg_status_basepage_regs u_kr_autoneg_status_basepage_regs (.*);
    an_engine_model u_an_engine_model (.clk_i, .lvl_o({negotiation_complete_i,
        receive_negotiation_idle_i, partner_negotiation_capable_i,
        fec_negotiated_i, sequencer_negotiation_failure_i}),
        .ready_o(resolved_link_ready_onehot_i), .ack_o(tx_ack_i),
        .nonce_o(tx_echoed_nonce_i), .prbs_o(tx_prbs_i));

    initial forever #5 clk_i = ~clk_i;

    // status as the live levels stand, sticky bits clear
    function automatic logic [31:0] exp_st();
        return {14'h0, resolved_link_ready_onehot_i, 2'h0,
            sequencer_negotiation_failure_i, fec_negotiated_i,
            partner_negotiation_capable_i, 2'h1, receive_negotiation_idle_i,
            1'b0, negotiation_complete_i, 2'h0};
    endfunction

    // byte-lane write limited to the writable bits
    function automatic logic [31:0] merge(input logic [31:0] o, n,
        input logic [3:0] s, input logic [31:0] m);
        logic [31:0] b;
        b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & m;
        return (o & ~b) | (n & b);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; snap holds the levels seen at the taken edge
    task automatic xfer(input logic [11:0] ix, input logic w,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        wb_adr_i <= {18'h0, ix, 2'h0};
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk_i);
        snap = exp_st();
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) chk(32'h0, 32'h1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // page and override outputs against the register model
    task automatic outs();
        logic [31:0] lo;
        lo = mdl[1];
        chk(32'(user_base_page_en_o), 32'(mdl[0][1]));
        chk(32'({advertised_pause_override_o, advertised_fec_override_o,
            advertised_technology_override_o}), mdl[0][5] ? 32'({lo[30:28],
            lo[25:24], lo[21:16]}) : 32'h0);
        chk(32'(user_base_page_o[45:16]), 32'(mdl[2][29:0]));
        chk(32'({user_base_page_o[49], user_base_page_o[15:0]}),
            32'({tx_prbs_i, lo[15], tx_ack_i, lo[13:10], tx_echoed_nonce_i,
            lo[4:0]}));
    endtask

    task automatic close_out();
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        idx = '{an_regs_pkg::IDX_CONTROL, an_regs_pkg::IDX_BP_LOW,
            an_regs_pkg::IDX_BP_HIGH, 12'h4FF};
        wm = '{an_regs_pkg::CTL_WMASK, an_regs_pkg::BPL_WMASK,
            32'hFFFF_FFFF, 32'h0};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, then random byte-lane writes with readback
        for (k = 0; k < 4; k++) begin
            mdl[k] = 32'h0;
            xfer(idx[k], 1'b0, 32'h0, 4'hF);
            chk(rdat, 32'h0);
        end
        for (int i = 0; i < 40; i++) begin
            k = $unsigned($random(seed)) % 4;
            wd = $random(seed);
            ws = (i < 2) ? 4'hF : 4'($random(seed));
            xfer(idx[k], 1'b1, wd, ws);
            mdl[k] = merge(mdl[k], wd, ws, wm[k]);
            xfer(idx[k], 1'b0, 32'h0, 4'hF);
            chk(rdat, mdl[k]);
            outs();
        end
        // status ignores writes; sticky bits set by one pulse, cleared
        xfer(an_regs_pkg::IDX_STATUS, 1'b1, 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 20; i++) begin
            xfer(an_regs_pkg::IDX_STATUS, 1'b0, 32'h0, 4'hF);
            chk(rdat, snap);
        end
        for (int b = 0; b < 3; b++) begin
            {link_up_i, remote_fault_sent_i, page_received_i} <= 3'(1 << b);
            @(posedge clk_i);
            {link_up_i, remote_fault_sent_i, page_received_i} <= 3'h0;
            xfer(an_regs_pkg::IDX_STATUS, 1'b0, 32'h0, 4'hF);
            chk(rdat, snap | (b == 0 ? 32'h2 : b == 1 ? 32'h8 : 32'h40));
            xfer(an_regs_pkg::IDX_STATUS, 1'b0, 32'h0, 4'hF);
            chk(rdat, snap);
        end
        // clock enable low: an event on a frozen edge must not stick
        ce_i <= 1'b0;
        page_received_i <= 1'b1;
        @(posedge clk_i);
        page_received_i <= 1'b0;
        ce_i <= 1'b1;
        xfer(an_regs_pkg::IDX_STATUS, 1'b0, 32'h0, 4'hF);
        chk(rdat, snap);
        close_out();
    end

    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule : kr_autoneg_status_basepage_regs_tb
`default_nettype wire
